/* logic/bit_branch_pkg.sv */
// Contract
// - 128 ram bits plus 128 special-function bits
// - 00h-7Fh ram page, 80h-FFh function space
// - operand bit chosen by direct instruction address
// - each port line written alone
// - carry is accumulator, also directly addressable
// - copy, clear, set, invert carry or bit
// - and/or carry with bit or inverse; no xor
// - branch on carry or bit, high or low
// - test-and-clear branches on one, clears bit
// - every status word bit is bit addressable
// - relative branch adds signed byte to pc
// - short relative jump is two bytes
// - long jump three bytes, full 16-bit target
// - page jump replaces low 11 pc bits
// - computed jump targets pointer plus accumulator
// - long call 16-bit, page call 11-bit block
// - return resumes after the originating call
// - interrupt exit is return plus irq_finished notice
// - zero tests look at the accumulator directly
// - count down branches while result nonzero
// - compare sets carry when first is smaller
package bit_branch_pkg;

  // ************************************************************
  // widths and depths
  // ************************************************************
  localparam int unsigned PC_W        = 16;
  localparam int unsigned RAM_BITS    = 128;
  localparam int unsigned SFR_BYTES   = 16;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned STACK_AW    = 3;

  // ************************************************************
  // bit-addressable function bytes (index = address bits 6:3)
  // ************************************************************
  localparam logic [3:0] PORT0_IDX  = 4'h0;
  localparam logic [3:0] PORT1_IDX  = 4'h2;
  localparam logic [3:0] PORT2_IDX  = 4'h4;
  localparam logic [3:0] PORT3_IDX  = 4'h6;
  localparam logic [3:0] STATUS_IDX = 4'ha;
  localparam logic [3:0] ACC_IDX    = 4'hc;
  localparam logic [2:0] CARRY_POS  = 3'h7;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] SFR_RESET  = 8'h00;

  // ************************************************************
  // opcode encodings
  // ************************************************************
  localparam logic [7:0] OP_IDLE      = 8'h00;
  localparam logic [4:0] OP_PAGE_JUMP = 5'h01;
  localparam logic [4:0] OP_PAGE_CALL = 5'h11;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_RET       = 8'h22;
  localparam logic [7:0] OP_IRQ_EXIT  = 8'h32;
  localparam logic [7:0] OP_SHORT_JMP = 8'h80;
  localparam logic [7:0] OP_CALC_JMP  = 8'h73;
  localparam logic [7:0] OP_JTC       = 8'h10;
  localparam logic [7:0] OP_JBH       = 8'h20;
  localparam logic [7:0] OP_JBL       = 8'h30;
  localparam logic [7:0] OP_JCH       = 8'h40;
  localparam logic [7:0] OP_JCL       = 8'h50;
  localparam logic [7:0] OP_JAZ       = 8'h60;
  localparam logic [7:0] OP_JANZ      = 8'h70;
  localparam logic [7:0] OP_OR_BIT    = 8'h72;
  localparam logic [7:0] OP_AND_BIT   = 8'h82;
  localparam logic [7:0] OP_COPY_TO_B = 8'h92;
  localparam logic [7:0] OP_OR_NBIT   = 8'ha0;
  localparam logic [7:0] OP_COPY_TO_C = 8'ha2;
  localparam logic [7:0] OP_AND_NBIT  = 8'hb0;
  localparam logic [7:0] OP_INV_BIT   = 8'hb2;
  localparam logic [7:0] OP_INV_C     = 8'hb3;
  localparam logic [7:0] OP_CLR_BIT   = 8'hc2;
  localparam logic [7:0] OP_CLR_C     = 8'hc3;
  localparam logic [7:0] OP_SET_BIT   = 8'hd2;
  localparam logic [7:0] OP_SET_C     = 8'hd3;
  localparam logic [7:0] OP_CDB_DIR   = 8'hd5;
  localparam logic [4:0] OP_CDB_REG   = 5'h1b;
  localparam logic [3:0] OP_CMP_HI    = 4'hb;
  localparam logic [3:0] OP_CMP_LO    = 4'h4;

  // ************************************************************
  // instruction lengths in bytes
  // ************************************************************
  localparam logic [1:0] LEN_ONE   = 2'd1;
  localparam logic [1:0] LEN_TWO   = 2'd2;
  localparam logic [1:0] LEN_THREE = 2'd3;

  // decoded instruction classes
  typedef enum logic [4:0] {
    CL_IDLE, CL_PAGE_JUMP, CL_PAGE_CALL, CL_LONG_JUMP, CL_LONG_CALL,
    CL_RET, CL_IRQ_EXIT, CL_SHORT_JMP, CL_CALC_JMP, CL_JTC, CL_JBH,
    CL_JBL, CL_JCH, CL_JCL, CL_JAZ, CL_JANZ, CL_OR_BIT, CL_OR_NBIT,
    CL_AND_BIT, CL_AND_NBIT, CL_COPY_TO_B, CL_COPY_TO_C, CL_INV_BIT,
    CL_INV_C, CL_CLR_BIT, CL_CLR_C, CL_SET_BIT, CL_SET_C, CL_CDB_DIR,
    CL_CDB_REG, CL_CMP, CL_OTHER
  } op_class_e;

endpackage : bit_branch_pkg

/* logic/bit_branch_unit.sv */
`timescale 1ns/1ps
// single-bit processor and program-flow executor, one instruction per cycle
module bit_branch_unit (
  input  wire logic                            core_clk,         // core clock
  input  wire logic                            rst_n,            // sync reset, low
  input  wire logic                            instr_valid,      // instruction offered
  output logic                                 instr_ready,      // always accepts
  input  wire logic [7:0]                      opcode,           // first byte
  input  wire logic [7:0]                      byte1,            // second byte
  input  wire logic [7:0]                      byte2,            // third byte
  input  wire logic [bit_branch_pkg::PC_W-1:0] instr_pc,         // address of opcode
  input  wire logic [15:0]                     pointer_register, // data pointer
  input  wire logic                            acc_load,         // datapath writes acc
  input  wire logic [7:0]                      acc_load_data,    // value for acc
  input  wire logic [7:0]                      count_in,         // count-down operand
  input  wire logic [7:0]                      cmp_first,        // compare first byte
  input  wire logic [7:0]                      cmp_second,       // compare second byte
  output logic                                 done,             // result pulse
  output logic [bit_branch_pkg::PC_W-1:0]      next_pc,          // pc after instr
  output logic                                 branch_taken,     // flow changed
  output logic                                 irq_finished,     // interrupt exit pulse
  output logic                                 count_wr,         // count result valid
  output logic [7:0]                           count_out,        // decremented count
  output logic [31:0]                          port_out,         // ports 3..0 latches
  output logic [7:0]                           status_word,      // status byte
  output logic [7:0]                           acc               // accumulator
);
  import bit_branch_pkg::*;

  // ************************************************************
  // storage
  // ************************************************************
  logic [RAM_BITS-1:0] ram_bits_q;
  logic [7:0]          sfr_q [SFR_BYTES];

  logic                done_q;
  logic [PC_W-1:0]     next_pc_q;
  logic                taken_q;
  logic                irq_fin_q;
  logic                count_wr_q;
  logic [7:0]          count_q;

  // ************************************************************
  // decode
  // ************************************************************
  op_class_e           op_class;
  logic [1:0]          op_len;
  logic [PC_W-1:0]     pc_after;
  logic [7:0]          rel_byte;
  logic [PC_W-1:0]     rel_target;
  logic [PC_W-1:0]     page_target;
  logic [PC_W-1:0]     calc_target;
  logic [PC_W-1:0]     ret_addr;

  // ************************************************************
  // execute
  // ************************************************************
  logic [7:0]          bit_addr;
  logic                bit_in_sfr;
  logic                bit_val;
  logic                carry;
  logic                carry_wr;
  logic                carry_new;
  logic                bit_wr;
  logic                bit_new;
  logic                taken;
  logic [PC_W-1:0]     target;
  logic                push;
  logic                pop;
  logic                irq_exit;
  logic                cdb_wr;
  logic [7:0]          cdb_val;
  logic                fire;

  assign instr_ready = 1'b1;
  assign fire        = instr_valid;

  // opcode to class and length
  always_comb begin
    op_class = CL_OTHER;
    op_len   = LEN_ONE;
    case (opcode)
      OP_IDLE:      begin op_class = CL_IDLE;      op_len = LEN_ONE;   end
      OP_LONG_JUMP: begin op_class = CL_LONG_JUMP; op_len = LEN_THREE; end
      OP_LONG_CALL: begin op_class = CL_LONG_CALL; op_len = LEN_THREE; end
      OP_RET:       begin op_class = CL_RET;       op_len = LEN_ONE;   end
      OP_IRQ_EXIT:  begin op_class = CL_IRQ_EXIT;  op_len = LEN_ONE;   end
      OP_SHORT_JMP: begin op_class = CL_SHORT_JMP; op_len = LEN_TWO;   end
      OP_CALC_JMP:  begin op_class = CL_CALC_JMP;  op_len = LEN_ONE;   end
      OP_JTC:       begin op_class = CL_JTC;       op_len = LEN_THREE; end
      OP_JBH:       begin op_class = CL_JBH;       op_len = LEN_THREE; end
      OP_JBL:       begin op_class = CL_JBL;       op_len = LEN_THREE; end
      OP_JCH:       begin op_class = CL_JCH;       op_len = LEN_TWO;   end
      OP_JCL:       begin op_class = CL_JCL;       op_len = LEN_TWO;   end
      OP_JAZ:       begin op_class = CL_JAZ;       op_len = LEN_TWO;   end
      OP_JANZ:      begin op_class = CL_JANZ;      op_len = LEN_TWO;   end
      OP_OR_BIT:    begin op_class = CL_OR_BIT;    op_len = LEN_TWO;   end
      OP_OR_NBIT:   begin op_class = CL_OR_NBIT;   op_len = LEN_TWO;   end
      OP_AND_BIT:   begin op_class = CL_AND_BIT;   op_len = LEN_TWO;   end
      OP_AND_NBIT:  begin op_class = CL_AND_NBIT;  op_len = LEN_TWO;   end
      OP_COPY_TO_B: begin op_class = CL_COPY_TO_B; op_len = LEN_TWO;   end
      OP_COPY_TO_C: begin op_class = CL_COPY_TO_C; op_len = LEN_TWO;   end
      OP_INV_BIT:   begin op_class = CL_INV_BIT;   op_len = LEN_TWO;   end
      OP_INV_C:     begin op_class = CL_INV_C;     op_len = LEN_ONE;   end
      OP_CLR_BIT:   begin op_class = CL_CLR_BIT;   op_len = LEN_TWO;   end
      OP_CLR_C:     begin op_class = CL_CLR_C;     op_len = LEN_ONE;   end
      OP_SET_BIT:   begin op_class = CL_SET_BIT;   op_len = LEN_TWO;   end
      OP_SET_C:     begin op_class = CL_SET_C;     op_len = LEN_ONE;   end
      OP_CDB_DIR:   begin op_class = CL_CDB_DIR;   op_len = LEN_THREE; end
      default: begin
        if (opcode[4:0] == OP_PAGE_JUMP) begin
          op_class = CL_PAGE_JUMP;
          op_len   = LEN_TWO;
        end else if (opcode[4:0] == OP_PAGE_CALL) begin
          op_class = CL_PAGE_CALL;
          op_len   = LEN_TWO;
        end else if (opcode[7:3] == OP_CDB_REG) begin
          op_class = CL_CDB_REG;
          op_len   = LEN_TWO;
        end else if (opcode[7:4] == OP_CMP_HI && opcode[3:2] != 2'b00) begin
          op_class = CL_CMP;
          op_len   = LEN_THREE;
        end else if (opcode[7:4] == OP_CMP_HI && opcode[3:0] == OP_CMP_LO) begin
          op_class = CL_CMP;
          op_len   = LEN_THREE;
        end else begin
          op_class = CL_OTHER;
          op_len   = LEN_ONE;
        end
      end
    endcase
  end

  // ************************************************************
  // targets
  // ************************************************************
  // pc steps past every byte before any offset or page substitution
  assign pc_after = instr_pc + {14'h0000, op_len};

  // three-byte forms carry the offset in the last byte
  assign rel_byte = (op_len == LEN_THREE) ? byte2 : byte1;

  // signed offset, reach -128..+127 from the following byte
  assign rel_target = pc_after + {{8{rel_byte[7]}}, rel_byte};

  // low 11 bits replaced, upper 5 kept from the following instruction
  assign page_target = {pc_after[15:11], opcode[7:5], byte1};

  // case jump computed at execution time
  assign calc_target = pointer_register + {8'h00, acc};

  // ************************************************************
  // bit operand
  // ************************************************************
  // the operand is always the direct address in the second byte
  assign bit_addr   = byte1;
  assign bit_in_sfr = bit_addr[7];
  assign carry      = sfr_q[STATUS_IDX][CARRY_POS];

  // 00h-7Fh read the ram page, 80h-FFh the function bytes
  always_comb begin
    if (bit_in_sfr) begin
      bit_val = sfr_q[bit_addr[6:3]][bit_addr[2:0]];
    end else begin
      bit_val = ram_bits_q[bit_addr[6:0]];
    end
  end

  // ************************************************************
  // execute
  // ************************************************************
  // carry, bit, flow and stack effects of the offered instruction
  always_comb begin
    carry_wr  = 1'b0;
    carry_new = carry;
    bit_wr    = 1'b0;
    bit_new   = bit_val;
    taken     = 1'b0;
    target    = pc_after;
    push      = 1'b0;
    pop       = 1'b0;
    irq_exit  = 1'b0;
    cdb_wr    = 1'b0;
    cdb_val   = count_in - 8'h01;
    case (op_class)
      CL_AND_BIT:   begin carry_wr = 1'b1; carry_new = carry & bit_val;  end
      CL_AND_NBIT:  begin carry_wr = 1'b1; carry_new = carry & ~bit_val; end
      CL_OR_BIT:    begin carry_wr = 1'b1; carry_new = carry | bit_val;  end
      CL_OR_NBIT:   begin carry_wr = 1'b1; carry_new = carry | ~bit_val; end
      CL_COPY_TO_C: begin carry_wr = 1'b1; carry_new = bit_val;          end
      CL_COPY_TO_B: begin bit_wr   = 1'b1; bit_new   = carry;            end
      CL_CLR_C:     begin carry_wr = 1'b1; carry_new = 1'b0;             end
      CL_SET_C:     begin carry_wr = 1'b1; carry_new = 1'b1;             end
      CL_INV_C:     begin carry_wr = 1'b1; carry_new = ~carry;           end
      CL_CLR_BIT:   begin bit_wr   = 1'b1; bit_new   = 1'b0;             end
      CL_SET_BIT:   begin bit_wr   = 1'b1; bit_new   = 1'b1;             end
      CL_INV_BIT:   begin bit_wr   = 1'b1; bit_new   = ~bit_val;         end
      CL_JCH:       begin taken = carry;    target = rel_target; end
      CL_JCL:       begin taken = ~carry;   target = rel_target; end
      CL_JBH:       begin taken = bit_val;  target = rel_target; end
      CL_JBL:       begin taken = ~bit_val; target = rel_target; end
      CL_JTC: begin
        // branch on one and clear in the same step
        taken   = bit_val;
        target  = rel_target;
        bit_wr  = bit_val;
        bit_new = 1'b0;
      end
      CL_JAZ:       begin taken = (acc == 8'h00); target = rel_target; end
      CL_JANZ:      begin taken = (acc != 8'h00); target = rel_target; end
      CL_SHORT_JMP: begin taken = 1'b1; target = rel_target;  end
      CL_LONG_JUMP: begin taken = 1'b1; target = {byte1, byte2}; end
      CL_PAGE_JUMP: begin taken = 1'b1; target = page_target; end
      CL_CALC_JMP:  begin taken = 1'b1; target = calc_target; end
      CL_LONG_CALL: begin
        taken  = 1'b1;
        target = {byte1, byte2};
        push   = 1'b1;
      end
      CL_PAGE_CALL: begin
        taken  = 1'b1;
        target = page_target;
        push   = 1'b1;
      end
      CL_RET: begin
        taken  = 1'b1;
        target = ret_addr;
        pop    = 1'b1;
      end
      CL_IRQ_EXIT: begin
        taken    = 1'b1;
        target   = ret_addr;
        pop      = 1'b1;
        irq_exit = 1'b1;
      end
      CL_CDB_DIR, CL_CDB_REG: begin
        cdb_wr = 1'b1;
        taken  = (cdb_val != 8'h00);
        target = rel_target;
      end
      CL_CMP: begin
        carry_wr  = 1'b1;
        carry_new = (cmp_first < cmp_second);
        taken     = (cmp_first != cmp_second);
        target    = rel_target;
      end
      CL_IDLE: begin
        taken = 1'b0;
      end
      default: begin
        taken = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // return addresses
  // ************************************************************
  // the stored address is the instruction following the call
  return_stack u_return_stack (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .push      (fire && push),
    .pop       (fire && pop),
    .push_addr (pc_after),
    .top_addr  (ret_addr)
  );

  // ************************************************************
  // bit storage updates
  // ************************************************************
  // ram bit page, one bit written per instruction
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ram_bits_q <= '0;
    end else if (fire && bit_wr && !bit_in_sfr) begin
      ram_bits_q[bit_addr[6:0]] <= bit_new;
    end
  end

  // function bytes: acc load, then carry, then the addressed bit wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SFR_BYTES; i++) begin
        sfr_q[i] <= SFR_RESET;
      end
      sfr_q[PORT0_IDX] <= PORT_RESET;
      sfr_q[PORT1_IDX] <= PORT_RESET;
      sfr_q[PORT2_IDX] <= PORT_RESET;
      sfr_q[PORT3_IDX] <= PORT_RESET;
    end else begin
      if (acc_load) begin
        sfr_q[ACC_IDX] <= acc_load_data;
      end
      if (fire && carry_wr) begin
        sfr_q[STATUS_IDX][CARRY_POS] <= carry_new;
      end
      if (fire && bit_wr && bit_in_sfr) begin
        // only the one addressed line changes
        sfr_q[bit_addr[6:3]][bit_addr[2:0]] <= bit_new;
      end
    end
  end

  // ************************************************************
  // results
  // ************************************************************
  // flow result registered one cycle after the instruction is taken
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_q    <= 1'b0;
      next_pc_q <= '0;
      taken_q   <= 1'b0;
      irq_fin_q <= 1'b0;
    end else begin
      done_q    <= fire;
      irq_fin_q <= fire && irq_exit;
      if (fire) begin
        next_pc_q <= taken ? target : pc_after;
        taken_q   <= taken;
      end
    end
  end

  // decremented count handed back for the datapath to store
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_wr_q <= 1'b0;
      count_q    <= 8'h00;
    end else begin
      count_wr_q <= fire && cdb_wr;
      if (fire && cdb_wr) begin
        count_q <= cdb_val;
      end
    end
  end

  // outputs straight from flops
  assign done         = done_q;
  assign next_pc      = next_pc_q;
  assign branch_taken = taken_q;
  assign irq_finished = irq_fin_q;
  assign count_wr     = count_wr_q;
  assign count_out    = count_q;
  assign port_out     = {sfr_q[PORT3_IDX], sfr_q[PORT2_IDX],
                         sfr_q[PORT1_IDX], sfr_q[PORT0_IDX]};
  assign status_word  = sfr_q[STATUS_IDX];
  assign acc          = sfr_q[ACC_IDX];

endmodule : bit_branch_unit

/* logic/return_stack.sv */
`timescale 1ns/1ps
// small lifo of return addresses for calls and returns
module return_stack (
  input  wire logic                              core_clk,  // core clock
  input  wire logic                              rst_n,     // sync reset, low
  input  wire logic                              push,      // store an address
  input  wire logic                              pop,       // drop top address
  input  wire logic [bit_branch_pkg::PC_W-1:0]   push_addr, // address to store
  output logic      [bit_branch_pkg::PC_W-1:0]   top_addr   // most recent address
);
  import bit_branch_pkg::*;

  logic [PC_W-1:0]     mem_q [STACK_DEPTH];
  logic [STACK_AW-1:0] ptr_q;
  logic [STACK_AW-1:0] top_idx;

  // ************************************************************
  // storage
  // ************************************************************
  // top entry sits one below the write pointer; wraps when over-deep
  assign top_idx  = ptr_q - 3'd1;
  assign top_addr = mem_q[top_idx];

  // pointer moves one way per push or pop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (push && !pop) begin
      ptr_q <= ptr_q + 3'd1;
    end else if (pop && !push) begin
      ptr_q <= top_idx;
    end
  end

  // entries are written on push only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push && !pop) begin
      mem_q[ptr_q] <= push_addr;
    end
  end

endmodule : return_stack

/* test/bit_branch_chk.sv */
`timescale 1ns/1ps
// **********
// flow and carry checks
// **********
module bit_branch_chk
  import bit_branch_pkg::*;
(
  input wire logic                            core_clk,         // clock
  input wire logic                            rst_n,            // reset, low
  input wire logic                            instr_valid,      // offered
  input wire logic [7:0]                      opcode,           // byte 0
  input wire logic [7:0]                      byte1,            // byte 1
  input wire logic [7:0]                      byte2,            // byte 2
  input wire logic [bit_branch_pkg::PC_W-1:0] instr_pc,         // pc
  input wire logic [15:0]                     pointer_register, // pointer
  input wire logic [7:0]                      count_in,         // count
  input wire logic [7:0]                      cmp_first,        // first
  input wire logic [7:0]                      cmp_second,       // second
  input wire logic [bit_branch_pkg::PC_W-1:0] next_pc,          // next pc
  input wire logic                            branch_taken,     // taken
  input wire logic                            irq_finished,     // exit
  input wire logic                            count_wr,         // count pulse
  input wire logic [7:0]                      count_out,        // count
  input wire logic [7:0]                      status_word,      // status
  input wire logic [7:0]                      acc               // acc
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // targets worked out from the instruction bytes
  logic [15:0] pc2, rel_t, abs_t, calc_t;
  logic        a_zero, lt, is_exit, is_cmp;
  assign pc2     = instr_pc + 16'h2;
  assign rel_t   = pc2 + {{8{byte1[7]}}, byte1};
  assign abs_t   = {pc2[15:11], opcode[7:5], byte1};
  assign calc_t  = pointer_register + {8'h00, acc};
  assign a_zero  = (acc == 8'h00);
  assign lt      = (cmp_first < cmp_second);
  assign is_exit = (opcode == OP_IRQ_EXIT);
  assign is_cmp  = (opcode[7:4] == OP_CMP_HI) && (opcode[3:0] >= OP_CMP_LO);
  sequence s_call; instr_valid && opcode == OP_LONG_CALL; endsequence
  sequence s_ret; instr_valid && opcode == OP_RET; endsequence
  property p_invc;
    instr_valid && opcode == OP_INV_C |=> status_word[7] != $past(status_word[7]);
  endproperty
  a_invc: assert property (p_invc) else $error("carry not inverted");
  property p_short_relative_jump;
    instr_valid && opcode == OP_SHORT_JMP |=> branch_taken && next_pc == $past(rel_t);
  endproperty
  a_short_relative_jump: assert property (p_short_relative_jump) else $error("short jump target");
  property p_long_jump;
    instr_valid && opcode == OP_LONG_JUMP |=> next_pc == {$past(byte1), $past(byte2)};
  endproperty
  a_long_jump: assert property (p_long_jump) else $error("long jump target");
  property p_page_jump;
    instr_valid && opcode[4:0] == OP_PAGE_JUMP |=> next_pc == $past(abs_t);
  endproperty
  a_page_jump: assert property (p_page_jump) else $error("page jump target");
  property p_calc;
    instr_valid && opcode == OP_CALC_JMP |=> next_pc == $past(calc_t);
  endproperty
  a_calc: assert property (p_calc) else $error("computed jump target");
  property p_ret;
    s_call ##1 s_ret |=> next_pc == $past(instr_pc, 2) + 16'h3;
  endproperty
  a_ret: assert property (p_ret) else $error("return address");
  property p_exit;
    instr_valid && (opcode == OP_RET || is_exit) |=> irq_finished == $past(is_exit);
  endproperty
  a_exit: assert property (p_exit) else $error("exit notice");
  property p_jz;
    instr_valid && opcode == OP_JAZ |=> branch_taken == $past(a_zero);
  endproperty
  a_jz: assert property (p_jz) else $error("acc zero test");
  property p_count_down_branch;
    instr_valid && (opcode == OP_CDB_DIR || opcode[7:3] == OP_CDB_REG) |=> count_wr &&
      count_out == $past(count_in) - 8'h1 && branch_taken == ($past(count_in) != 8'h1);
  endproperty
  a_count_down_branch: assert property (p_count_down_branch) else $error("count down");
  property p_cmp;
    instr_valid && is_cmp |=> status_word[7] == $past(lt);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare carry");
endmodule : bit_branch_chk
bind bit_branch_unit bit_branch_chk i_bit_branch_chk (.*);

/* test/tb_top.sv */
`timescale 1ns/1ps
// **********
// bench for the bit and branch unit
// **********
module tb_top;
  import bit_branch_pkg::*;
  logic core_clk, rst_n, instr_valid, acc_load, instr_ready, done, branch_taken;
  logic irq_finished, count_wr;
  logic [7:0] opcode, byte1, byte2, acc_load_data, count_in, cmp_first, cmp_second;
  logic [7:0] count_out, status_word, acc;
  logic [15:0] instr_pc, pointer_register, next_pc;
  logic [31:0] port_out;
  int err_total, n_tests, cyc;
  bit_branch_unit i_bit_branch_unit (.*);
  // clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one instruction, results settled on return
  task automatic ex(logic [7:0] op, logic [7:0] b1 = 8'h0, logic [7:0] b2 = 8'h0,
                    logic [15:0] pc = 16'h1000);
    opcode = op;
    byte1 = b1;
    byte2 = b2;
    instr_pc = pc;
    instr_valid = 1'b1;
    @(posedge core_clk);
    #1;
  endtask : ex
  task automatic t_bits;
    ex(OP_SET_C);
    chk("carry", status_word[7], 1);
    ex(OP_INV_C);
    chk("carry", status_word[7], 0);
    ex(OP_COPY_TO_B, 8'h90);
    chk("port1", port_out[15:8], 8'hfe);
    ex(OP_SET_C);
    ex(OP_COPY_TO_C, 8'h90);
    chk("carry", status_word[7], 0);
    ex(OP_SET_BIT, 8'hd0);
    chk("status", status_word, 8'h01);
    ex(OP_CLR_BIT, 8'hd0);
    ex(OP_INV_BIT, 8'h05);
    ex(OP_SET_C);
    ex(OP_AND_NBIT, 8'h05);
    chk("carry", status_word[7], 0);
    ex(OP_OR_BIT, 8'h05);
    chk("carry", status_word[7], 1);
    ex(OP_AND_BIT, 8'h06);
    chk("carry", status_word[7], 0);
    ex(OP_OR_NBIT, 8'h06);
    chk("carry", status_word[7], 1);
  endtask : t_bits
  task automatic t_flow;
    ex(OP_JTC, 8'h05, 8'h80);
    chk("pc", next_pc, 16'h0f83);
    chk("taken", branch_taken, 1);
    ex(OP_JBH, 8'h05, 8'h10);
    chk("pc", next_pc, 16'h1003);
    ex(OP_JCH, 8'h7f);
    chk("pc", next_pc, 16'h1081);
    ex(OP_JCL, 8'h7f);
    chk("pc", next_pc, 16'h1002);
    ex(OP_SHORT_JMP, 8'hfe);
    chk("pc", next_pc, 16'h1000);
    ex(OP_LONG_JUMP, 8'h12, 8'h34);
    chk("pc", next_pc, 16'h1234);
    ex(8'he1, 8'h55, 8'h0, 16'h37fe);
    chk("pc", next_pc, 16'h3f55);
    acc_load = 1'b1;
    acc_load_data = 8'h08;
    ex(OP_IDLE);
    acc_load = 1'b0;
    chk("pc", next_pc, 16'h1001);
    chk("done", done, 1);
    chk("ready", instr_ready, 1);
    chk("acc", acc, 8'h08);
    ex(OP_CALC_JMP);
    chk("pc", next_pc, 16'h0004);
    ex(OP_JAZ, 8'h20);
    chk("taken", branch_taken, 0);
    ex(OP_JANZ, 8'h20);
    chk("pc", next_pc, 16'h1022);
    ex(OP_LONG_CALL, 8'h20, 8'h00, 16'h0100);
    ex(OP_RET, 8'h0, 8'h0, 16'h2000);
    chk("pc", next_pc, 16'h0103);
    ex(8'h31, 8'h10, 8'h0, 16'h0ffe);
    chk("pc", next_pc, 16'h1110);
    ex(OP_IRQ_EXIT, 8'h0, 8'h0, 16'h1110);
    chk("exit", irq_finished, 1);
    chk("pc", next_pc, 16'h1000);
  endtask : t_flow
  task automatic t_count;
    count_in = 8'h01;
    ex(OP_CDB_DIR, 8'h30, 8'h10);
    chk("pc", next_pc, 16'h1003);
    count_in = 8'h00;
    ex(OP_CDB_DIR, 8'h30, 8'h10);
    chk("cnt", count_out, 8'hff);
    count_in = 8'h02;
    ex(8'hd9, 8'h10);
    chk("pc", next_pc, 16'h1012);
    cmp_first = 8'h03;
    ex(8'hb5, 8'h05, 8'h10);
    chk("carry", status_word[7], 1);
    cmp_first = 8'h05;
    ex(8'hb5, 8'h05, 8'h10);
    chk("taken", branch_taken, 0);
  endtask : t_count
  task automatic results;
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  initial begin
    {rst_n, instr_valid, acc_load, opcode, byte1, byte2, acc_load_data} = '0;
    {count_in, instr_pc, pointer_register} = {8'h00, 16'h1000, 16'hfffc};
    {cmp_first, cmp_second} = {8'h00, 8'h05};
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk("ports", port_out[15:0], 16'hffff);
    chk("done", done, 0);
    t_bits();
    t_flow();
    t_count();
    results();
  end
endmodule : tb_top
